// file: flash_lock_pkg.sv
// shared constants for the flash sector lock and timing block
package flash_lock_pkg;

	// register addresses on the 12-bit register port
	localparam logic [11:0] FLASH_CTRL_ADDR = 12'hFF8;
	localparam logic [11:0] SECTOR_LOCK_ADDR = 12'hFF9;
	localparam logic [11:0] CLK_KHZ_HIGH_ADDR = 12'hFFA;
	localparam logic [11:0] CLK_KHZ_LOW_ADDR = 12'hFFB;

	// key that arms the shared address for the lock register
	localparam logic [7:0] LOCK_KEY = 8'h5E;

	// reset values
	localparam logic [7:0] SECTOR_LOCK_RESET = 8'h00;
	localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
	localparam logic [7:0] CLK_KHZ_BYTE_RESET = 8'h00;

	// status fields read back at the control address
	localparam int STATUS_ARMED_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;
	localparam int STATUS_REFUSED_BIT = 2;
	localparam int STATUS_DONE_BIT = 3;

	// lock bit count and sector sizes in bytes
	localparam int SECTOR_COUNT = 8;
	localparam int SECTOR_BYTES_LARGE = 1024;
	localparam int SECTOR_BYTES_SMALL = 512;

	// array sizes in kilobytes that change the sector map
	localparam int FLASH_KB_LARGE = 8;
	localparam int FLASH_KB_2K = 2;
	localparam int FLASH_KB_1K = 1;

	// operation lengths in milliseconds
	localparam int PROGRAM_TIME_MS = 1;
	localparam int ERASE_TIME_MS = 10;

	// operation states
	typedef enum logic [1:0]
	{
		OP_IDLE = 2'b01,
		OP_RUN = 2'b10
	} op_state_type;

endpackage

// file: sector_lock_bits.sv
// set-only sector lock bits with the unused bits of small arrays masked off
`timescale 1ns/1ps
module sector_lock_bits
	import flash_lock_pkg::*;
#(
	parameter logic [SECTOR_COUNT-1:0] USED_MASK = 8'hFF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// write from the register port
	input wire logic lock_write,
	input wire logic [SECTOR_COUNT-1:0] lock_wdata,
	// current lock bits
	output logic [SECTOR_COUNT-1:0] lock_bits
);

	logic [SECTOR_COUNT-1:0] lock_reg; // one bit per sector
	logic [SECTOR_COUNT-1:0] lock_next; // next lock bits

	// bits only ever set; unused bits stay zero
	always_comb
	begin
		lock_next = lock_reg;
		if (lock_write)
			lock_next = lock_reg | (lock_wdata & USED_MASK);
	end

	// power-up reset clears all, meaning unprotected
	always_ff @(posedge clk)
	begin
		if (reset)
			lock_reg <= SECTOR_LOCK_RESET;
		else
			lock_reg <= lock_next;
	end

	assign lock_bits = lock_reg;

endmodule // sector_lock_bits

// file: flash_op_timer.sv
// times a flash operation in milliseconds from the clock rate in kHz
`timescale 1ns/1ps
module flash_op_timer
	import flash_lock_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// start pulse and length in milliseconds
	input wire logic start,
	input wire logic [15:0] length_ms,
	// clock rate in kHz, equal to cycles per millisecond
	input wire logic [15:0] clk_khz,
	// running level and end pulse
	output logic busy,
	output logic done
);

	logic busy_reg; // operation running
	logic busy_next;
	logic done_reg; // one-cycle end marker
	logic done_next;
	logic [15:0] cyc_reg; // cycles inside the current millisecond
	logic [15:0] cyc_next;
	logic [15:0] ms_reg; // whole milliseconds elapsed
	logic [15:0] ms_next;
	logic ms_tick; // last cycle of a millisecond

	// a zero rate is treated as one cycle per millisecond
	always_comb
	begin
		ms_tick = (clk_khz == 16'h0000) || (cyc_reg == clk_khz - 16'h0001);
		busy_next = busy_reg;
		done_next = 1'b0;
		cyc_next = cyc_reg;
		ms_next = ms_reg;
		if (!busy_reg)
		begin
			// idle: wait for a start
			if (start)
			begin
				busy_next = 1'b1;
				cyc_next = 16'h0000;
				ms_next = 16'h0000;
			end
		end
		else if (ms_tick)
		begin
			// millisecond boundary
			cyc_next = 16'h0000;
			ms_next = ms_reg + 16'h0001;
			if (ms_reg + 16'h0001 >= length_ms)
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
		else
			cyc_next = cyc_reg + 16'h0001;
	end

	// register the timer state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			cyc_reg <= 16'h0000;
			ms_reg <= 16'h0000;
		end
		else
		begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			cyc_reg <= cyc_next;
			ms_reg <= ms_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;

endmodule // flash_op_timer

// file: flash_sector_lock_and_timing.sv
// flash sector lock, page select and clock-rate registers with op gate
`timescale 1ns/1ps
module flash_sector_lock_and_timing
	import flash_lock_pkg::*;
#(
	parameter int FLASH_KB = 8, // array size in kilobytes
	parameter int ADDR_WIDTH = 13, // byte address width of the array
	parameter logic [15:0] PROGRAM_MS = 16'(PROGRAM_TIME_MS),
	parameter logic [15:0] ERASE_MS = 16'(ERASE_TIME_MS)
)
(
	// clock and power-up reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// operation request from the flash sequencer
	input wire logic op_req,
	input wire logic op_erase,
	input wire logic [ADDR_WIDTH-1:0] op_addr,
	// operation results
	output logic op_accept,
	output logic op_refused,
	output logic op_done,
	output logic array_write_enable,
	output logic array_erase_enable,
	// register contents for the array logic
	output logic [7:0] page_select,
	output logic [SECTOR_COUNT-1:0] sector_lock_bits_out,
	output logic [15:0] flash_clock_khz_value
);

	// sector size and lock mask follow the array size
	localparam int SECTOR_BYTES = (FLASH_KB >= FLASH_KB_LARGE) ?
		SECTOR_BYTES_LARGE : SECTOR_BYTES_SMALL;
	localparam int SECTOR_SHIFT = $clog2(SECTOR_BYTES);
	localparam logic [SECTOR_COUNT-1:0] USED_MASK =
		(FLASH_KB == FLASH_KB_1K) ? 8'h03 :
		(FLASH_KB == FLASH_KB_2K) ? 8'h0F : 8'hFF;

	// sector number of a byte address, used for the lock check
	function automatic logic [2:0] sector_of(input logic [ADDR_WIDTH-1:0] a);
		logic [ADDR_WIDTH-1:0] s;
		s = a >> SECTOR_SHIFT;
		return s[2:0];
	endfunction

	// register port decode
	logic wr_ctrl; // write at the control address
	logic wr_shared; // write at the shared lock / page address
	logic wr_high; // write of the clock-rate high byte
	logic wr_low; // write of the clock-rate low byte
	logic lock_write; // shared write steered to the lock bits
	logic [SECTOR_COUNT-1:0] lock_bits; // current lock bits

	// armed flag and page select
	logic armed_reg; // key seen, next shared write goes to lock
	logic armed_next;
	logic [7:0] page_reg; // page select
	logic [7:0] page_next;

	// clock-rate bytes
	logic [7:0] khz_high_reg; // upper byte of the kHz value
	logic [7:0] khz_high_next;
	logic [7:0] khz_low_reg; // lower byte of the kHz value
	logic [7:0] khz_low_next;
	logic [15:0] clk_khz; // joined kHz value

	// read data
	logic [7:0] rdata_reg; // answer one cycle after the read strobe
	logic [7:0] rdata_next;

	// operation control
	op_state_type state_reg; // operation state
	op_state_type state_next;
	logic erase_reg; // running operation is an erase
	logic erase_next;
	logic accept_reg; // one-cycle accept marker
	logic accept_next;
	logic refused_reg; // one-cycle refuse marker
	logic refused_next;
	logic refused_sticky_reg; // last request was refused
	logic refused_sticky_next;
	logic done_sticky_reg; // last operation finished
	logic done_sticky_next;
	logic done_reg; // registered end pulse
	logic timer_start; // start the operation timer
	logic timer_busy; // operation timer running
	logic timer_done; // operation timer end pulse
	logic [15:0] op_length; // length of the started operation
	logic target_locked; // requested sector is locked
	logic write_en_reg; // program running, level to the array
	logic write_en_next;
	logic erase_en_reg; // erase running, level to the array
	logic erase_en_next;

	// address decode of the register port
	always_comb
	begin
		wr_ctrl = reg_write && (reg_addr == FLASH_CTRL_ADDR);
		wr_shared = reg_write && (reg_addr == SECTOR_LOCK_ADDR);
		wr_high = reg_write && (reg_addr == CLK_KHZ_HIGH_ADDR);
		wr_low = reg_write && (reg_addr == CLK_KHZ_LOW_ADDR);
		lock_write = wr_shared && armed_reg;
	end

	// key arming and page select steering
	always_comb
	begin
		armed_next = armed_reg;
		page_next = page_reg;
		if (wr_ctrl)
			armed_next = (reg_wdata == LOCK_KEY);
		else if (wr_shared)
		begin
			// the key covers one shared write only
			armed_next = 1'b0;
			if (!armed_reg)
				page_next = reg_wdata;
		end
	end

	// clock-rate bytes, software loads kHz
	always_comb
	begin
		khz_high_next = wr_high ? reg_wdata : khz_high_reg;
		khz_low_next = wr_low ? reg_wdata : khz_low_reg;
		clk_khz = {khz_high_reg, khz_low_reg};
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (reg_read)
		begin
			unique case (reg_addr)
				FLASH_CTRL_ADDR:
				begin
					// control address reads back status
					rdata_next[STATUS_ARMED_BIT] = armed_reg;
					rdata_next[STATUS_BUSY_BIT] = timer_busy;
					rdata_next[STATUS_REFUSED_BIT] = refused_sticky_reg;
					rdata_next[STATUS_DONE_BIT] = done_sticky_reg;
				end
				// shared address shows the lock bits while armed
				SECTOR_LOCK_ADDR: rdata_next = armed_reg ? lock_bits : page_reg;
				CLK_KHZ_HIGH_ADDR: rdata_next = khz_high_reg;
				CLK_KHZ_LOW_ADDR: rdata_next = khz_low_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// register port state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			armed_reg <= 1'b0;
			page_reg <= PAGE_SELECT_RESET;
			khz_high_reg <= CLK_KHZ_BYTE_RESET;
			khz_low_reg <= CLK_KHZ_BYTE_RESET;
			rdata_reg <= 8'h00;
		end
		else
		begin
			armed_reg <= armed_next;
			page_reg <= page_next;
			khz_high_reg <= khz_high_next;
			khz_low_reg <= khz_low_next;
			rdata_reg <= rdata_next;
		end
	end

	// set-only lock bits
	sector_lock_bits #(
		.USED_MASK(USED_MASK)
	) i_sector_lock_bits (
		.clk(clk),
		.reset(reset),
		.lock_write(lock_write),
		.lock_wdata(reg_wdata),
		.lock_bits(lock_bits)
	);

	// operation gate: check the lock of the target sector
	always_comb
	begin
		target_locked = lock_bits[sector_of(op_addr)];
		state_next = state_reg;
		erase_next = erase_reg;
		accept_next = 1'b0;
		refused_next = 1'b0;
		refused_sticky_next = refused_sticky_reg;
		done_sticky_next = done_sticky_reg;
		timer_start = 1'b0;
		// length follows the latched kind, not the live request pin
		op_length = erase_reg ? ERASE_MS : PROGRAM_MS;
		unique case (state_reg)
			OP_IDLE:
			begin
				// requests are taken only while idle
				if (op_req)
				begin
					if (target_locked)
					begin
						// locked sector stays untouched
						refused_next = 1'b1;
						refused_sticky_next = 1'b1;
					end
					else
					begin
						accept_next = 1'b1;
						refused_sticky_next = 1'b0;
						done_sticky_next = 1'b0;
						erase_next = op_erase;
						timer_start = 1'b1;
						state_next = OP_RUN;
					end
				end
			end
			OP_RUN:
			begin
				// hold the array enable until the timer ends
				if (timer_done)
				begin
					done_sticky_next = 1'b1;
					state_next = OP_IDLE;
				end
			end
			default: state_next = OP_IDLE;
		endcase
		// array enables follow the next state so they leave a flop
		write_en_next = (state_next == OP_RUN) && !erase_next;
		erase_en_next = (state_next == OP_RUN) && erase_next;
	end

	// operation state registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg <= OP_IDLE;
			erase_reg <= 1'b0;
			accept_reg <= 1'b0;
			refused_reg <= 1'b0;
			refused_sticky_reg <= 1'b0;
			done_sticky_reg <= 1'b0;
			done_reg <= 1'b0;
			write_en_reg <= 1'b0;
			erase_en_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			erase_reg <= erase_next;
			accept_reg <= accept_next;
			refused_reg <= refused_next;
			refused_sticky_reg <= refused_sticky_next;
			done_sticky_reg <= done_sticky_next;
			done_reg <= timer_done;
			write_en_reg <= write_en_next;
			erase_en_reg <= erase_en_next;
		end
	end

	// program and erase timing from the kHz value
	flash_op_timer i_flash_op_timer (
		.clk(clk),
		.reset(reset),
		.start(timer_start),
		.length_ms(op_length),
		.clk_khz(clk_khz),
		.busy(timer_busy),
		.done(timer_done)
	);

	// outputs, all from flip-flops
	assign reg_rdata = rdata_reg;
	assign op_accept = accept_reg;
	assign op_refused = refused_reg;
	assign op_done = done_reg;
	assign array_write_enable = write_en_reg;
	assign array_erase_enable = erase_en_reg;
	assign page_select = page_reg;
	assign sector_lock_bits_out = lock_bits;
	assign flash_clock_khz_value = clk_khz;

endmodule // flash_sector_lock_and_timing

// file: flash_lock_assertions.sv
// checker for the flash sector lock and timing block
`timescale 1ns/1ps
module flash_lock_assertions
	import flash_lock_pkg::*;
#(
	parameter int FLASH_KB = 8,
	parameter int ADDR_WIDTH = 13
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// operation port
	input wire logic op_req,
	input wire logic op_erase,
	input wire logic [ADDR_WIDTH-1:0] op_addr,
	input wire logic op_accept,
	input wire logic op_refused,
	input wire logic array_write_enable,
	input wire logic array_erase_enable,
	// register contents
	input wire logic [7:0] page_select,
	input wire logic [SECTOR_COUNT-1:0] sector_lock_bits_out,
	input wire logic [15:0] flash_clock_khz_value
);
	// lock bits that exist for this array size
	localparam logic [7:0] USED = (FLASH_KB >= 4) ? 8'hFF :
		(FLASH_KB == 2) ? 8'h0F : 8'h03;
	localparam int SHIFT = (FLASH_KB == 8) ? 10 : 9;
	logic armed_reg, armed_next; // key seen, shared write not yet made
	logic hit_lock; // request targets a locked sector
	logic idle; // no operation running
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// track the key the same way software sees it
	always_comb
	begin
		armed_next = armed_reg;
		if (reg_write && reg_addr == FLASH_CTRL_ADDR)
			armed_next = (reg_wdata == LOCK_KEY);
		else if (reg_write && reg_addr == SECTOR_LOCK_ADDR)
			armed_next = 1'b0;
		hit_lock = sector_lock_bits_out[3'(op_addr >> SHIFT)];
		idle = !(array_write_enable || array_erase_enable);
	end
	// key flag register, power-up clear
	always_ff @(posedge clk)
		armed_reg <= reset ? 1'b0 : armed_next;
	AST_KEY_TO_LOCK: assert property (reg_write && armed_reg &&
		reg_addr == SECTOR_LOCK_ADDR |=> $stable(page_select) &&
		sector_lock_bits_out == ($past(sector_lock_bits_out) |
		($past(reg_wdata) & USED))) else $error("keyed write missed lock");
	AST_PAGE_UNARMED: assert property (reg_write && !armed_reg &&
		reg_addr == SECTOR_LOCK_ADDR |=> $stable(sector_lock_bits_out) &&
		page_select == $past(reg_wdata)) else $error("page write wrong");
	AST_LOCK_KEEP: assert property (!$past(reset) |->
		(sector_lock_bits_out & $past(sector_lock_bits_out)) ==
		$past(sector_lock_bits_out)) else $error("lock bit cleared");
	AST_UNUSED_BITS: assert property ((sector_lock_bits_out & ~USED) ==
		8'h00) else $error("unused lock bit set");
	AST_KHZ_HIGH: assert property (reg_write &&
		reg_addr == CLK_KHZ_HIGH_ADDR |=> flash_clock_khz_value[15:8] ==
		$past(reg_wdata)) else $error("khz high byte wrong");
	AST_KHZ_LOW: assert property (reg_write &&
		reg_addr == CLK_KHZ_LOW_ADDR |=> flash_clock_khz_value[7:0] ==
		$past(reg_wdata)) else $error("khz low byte wrong");
	AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
	AST_REFUSE_LOCKED: assert property (op_req && idle && hit_lock
		|=> op_refused && !op_accept && !array_write_enable &&
		!array_erase_enable) else $error("locked sector not refused");
	AST_ACCEPT_OPEN: assert property (op_req && idle && !hit_lock
		|=> op_accept && !op_refused &&
		array_erase_enable == $past(op_erase)) else $error("open refused");
endmodule // flash_lock_assertions
bind flash_sector_lock_and_timing flash_lock_assertions
	#(.FLASH_KB(FLASH_KB), .ADDR_WIDTH(ADDR_WIDTH)) i_flash_lock_assertions
(
	.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.op_req(op_req), .op_erase(op_erase), .op_addr(op_addr),
	.op_accept(op_accept), .op_refused(op_refused),
	.array_write_enable(array_write_enable),
	.array_erase_enable(array_erase_enable), .page_select(page_select),
	.sector_lock_bits_out(sector_lock_bits_out),
	.flash_clock_khz_value(flash_clock_khz_value)
);

// file: tb_flash_sector_lock_and_timing.sv
// testbench for the flash sector lock and timing block
`timescale 1ns/1ps
module tb_flash_sector_lock_and_timing;
	import flash_lock_pkg::*;
	logic clk, reset, reg_write, reg_read, op_req, op_erase;
	logic op_accept, op_refused, op_done, wr_en, er_en;
	logic [11:0] reg_addr; // register port
	logic [7:0] reg_wdata, reg_rdata, page, lock, lock_2k, lock_1k;
	logic [12:0] op_addr; // request byte address
	logic [15:0] khz; // clock rate value
	int fails, checked;
	// main block, 8K map, short operation lengths
	flash_sector_lock_and_timing #(.PROGRAM_MS(16'h0001),
		.ERASE_MS(16'h0002)) i_flash_sector_lock_and_timing (.clk(clk),
		.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.op_req(op_req), .op_erase(op_erase), .op_addr(op_addr),
		.op_accept(op_accept), .op_refused(op_refused), .op_done(op_done),
		.array_write_enable(wr_en), .array_erase_enable(er_en),
		.page_select(page), .sector_lock_bits_out(lock),
		.flash_clock_khz_value(khz));
	// 2K map sharing all stimulus, only its lock bits are judged
	flash_sector_lock_and_timing #(.FLASH_KB(2), .ADDR_WIDTH(11))
		i_flash_sector_lock_and_timing_2k (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(), .op_req(op_req),
		.op_erase(op_erase), .op_addr(op_addr[10:0]), .op_accept(),
		.op_refused(), .op_done(), .array_write_enable(),
		.array_erase_enable(), .page_select(),
		.sector_lock_bits_out(lock_2k), .flash_clock_khz_value());
	// 1K map sharing all stimulus, only its lock bits are judged
	flash_sector_lock_and_timing #(.FLASH_KB(1), .ADDR_WIDTH(10))
		i_flash_sector_lock_and_timing_1k (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(), .op_req(op_req),
		.op_erase(op_erase), .op_addr(op_addr[9:0]), .op_accept(),
		.op_refused(), .op_done(), .array_write_enable(),
		.array_erase_enable(), .page_select(),
		.sector_lock_bits_out(lock_1k), .flash_clock_khz_value());
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// verdict and end of run
	task automatic stop_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// compare one value
	task automatic chk(input string name, input logic [15:0] exp, got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one write cycle, returns mid-cycle after it lands
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		@(negedge clk);
	endtask
	// one read cycle, data judged in the following cycle
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		chk("read data", 16'(exp), 16'(reg_rdata));
	endtask
	// request an operation; len is ms times kHz, 0 means refused
	task automatic op(input logic [12:0] a, input logic er, input int len);
		int n;
		@(posedge clk);
		op_req <= 1'b1;
		op_erase <= er;
		op_addr <= a;
		@(posedge clk);
		op_req <= 1'b0;
		@(negedge clk);
		chk("accept", 16'(len != 0), 16'(op_accept));
		chk("refused", 16'(len == 0), 16'(op_refused));
		n = 0;
		while ((wr_en || er_en) && n < 100)
		begin
			chk("erase enable", 16'(er), 16'(er_en));
			n++;
			@(negedge clk);
		end
		// the enable also stands in the cycle the timer hands over
		chk("enable cycles", 16'((len == 0) ? 0 : len + 1), 16'(n));
		chk("done", 16'(len != 0), 16'(op_done));
		if (n == 100)
			stop_test();
	endtask
	// everything clear after power-up
	task automatic t_reset();
		chk("lock", 16'h0000, 16'(lock));
		chk("page", 16'h0000, 16'(page));
		rd(SECTOR_LOCK_ADDR, 8'h00);
	endtask
	// shared address without key reaches page select, then keyed write
	task automatic t_key();
		wr(SECTOR_LOCK_ADDR, 8'hA5);
		chk("page", 16'h00A5, 16'(page));
		wr(FLASH_CTRL_ADDR, LOCK_KEY);
		rd(FLASH_CTRL_ADDR, 8'h01);
		wr(SECTOR_LOCK_ADDR, 8'h03);
		chk("lock", 16'h0003, 16'(lock));
		chk("page", 16'h00A5, 16'(page));
		wr(SECTOR_LOCK_ADDR, 8'h3C);
		chk("page", 16'h003C, 16'(page));
		chk("lock", 16'h0003, 16'(lock));
	endtask
	// bits only add up, and the small maps drop their upper bits
	task automatic t_noclear();
		wr(FLASH_CTRL_ADDR, LOCK_KEY);
		wr(SECTOR_LOCK_ADDR, 8'h1C);
		wr(FLASH_CTRL_ADDR, LOCK_KEY);
		wr(SECTOR_LOCK_ADDR, 8'h00);
		chk("lock", 16'h001F, 16'(lock));
		chk("lock 2k", 16'h000F, 16'(lock_2k));
		chk("lock 1k", 16'h0003, 16'(lock_1k));
		rd(SECTOR_LOCK_ADDR, 8'h3C);
	endtask
	// two bytes form the clock value, then load 4 kHz
	task automatic t_khz();
		wr(CLK_KHZ_HIGH_ADDR, 8'h12);
		wr(CLK_KHZ_LOW_ADDR, 8'h34);
		chk("khz", 16'h1234, khz);
		rd(CLK_KHZ_HIGH_ADDR, 8'h12);
		wr(CLK_KHZ_HIGH_ADDR, 8'h00);
		wr(CLK_KHZ_LOW_ADDR, 8'h04);
		rd(12'h000, 8'h00);
	endtask
	// 1024-byte sectors on the 8K map with bits 0 to 4 locked
	task automatic t_ops();
		op(13'h0600, 1'b0, 0);
		op(13'h1800, 1'b0, 4);
		op(13'h1000, 1'b1, 0);
		op(13'h1400, 1'b1, 8);
		rd(FLASH_CTRL_ADDR, 8'h08);
	endtask
	// main sequence
	initial
	begin
		reset = 1'b1;
		{reg_write, reg_read, op_req, op_erase} = 4'h0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		op_addr = 13'h0000;
		fails = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		t_reset();
		t_key();
		t_noclear();
		t_khz();
		t_ops();
		stop_test();
	end
endmodule // tb_flash_sector_lock_and_timing
